/* hw/kme_top.sv */
// Keypad matrix encoder: code outputs and debounced numeral strobe.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Four row and four column inputs.
// - Code valid only for one row, one column.
// - Other patterns illegal, code suppressed.
// - Strobe only for the ten numeral keys.
// - Inputs stable 80 clocks before strobe.
// - Strobe lasts one clock low phase; here it lasts one full clock period.
// - One strobe per numeral key press.
// - Release bounce gives no extra strobe.
// - One-key rollover: multiple keys give nothing.
// - Active low; numeral key code map.
// - Letter and symbol keys codes, no strobe.
// - Illegal patterns: code zero, no strobe.
module kme_top
   import kme_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic row_line_one_i,
   input wire logic row_line_two_i,
   input wire logic row_line_three_i,
   input wire logic row_line_four_i,
   input wire logic column_line_one_i,
   input wire logic column_line_two_i,
   input wire logic column_line_three_i,
   input wire logic column_line_four_i,
   output logic code_bit_zero_o,
   output logic code_bit_one_o,
   output logic code_bit_two_o,
   output logic code_bit_three_o,
   output logic strobe_o
);

   logic [KME_LINES-1:0] row_n;
   logic [KME_LINES-1:0] col_n;
   logic [2*KME_LINES-1:0] pat;
   logic legal;
   logic numeric;
   logic [KME_CODE_W-1:0] code;
   logic changed;
   logic at_last;
   logic no_key;

   logic [2*KME_LINES-1:0] pat_q;
   logic [KME_CNT_W-1:0] cnt_q;
   logic [KME_CNT_W-1:0] cnt_d;
   kme_state_e st_q;
   kme_state_e st_d;
   logic strobe_q;
   logic strobe_d;

   assign row_n = {row_line_four_i, row_line_three_i,
                   row_line_two_i, row_line_one_i};
   assign col_n = {column_line_four_i, column_line_three_i,
                   column_line_two_i, column_line_one_i};
   assign pat = {row_n, col_n};

   kme_decoder u_dec (
      .row_n_i(row_n),
      .col_n_i(col_n),
      .legal_o(legal),
      .numeric_o(numeric),
      .code_o(code)
   );

   // The code is deliberately not registered so that it tracks the keys
   // with no clock latency; of the outputs only the strobe is a flip-flop.
   assign code_bit_zero_o = code[0];
   assign code_bit_one_o = code[1];
   assign code_bit_two_o = code[2];
   assign code_bit_three_o = code[3];
   assign strobe_o = strobe_q;

   assign changed = (pat != pat_q);
   assign at_last = !changed && (cnt_q == KME_CNT_LAST);
   assign no_key = (row_n == KME_LINES_IDLE) && (col_n == KME_LINES_IDLE);

   // Stability counter: restarts on any input change and saturates.
   always_comb begin
      if (changed) begin
         cnt_d = KME_CNT_RESET;
      end else if (cnt_q != KME_CNT_LAST) begin
         cnt_d = cnt_q + 7'h01;
      end else begin
         cnt_d = cnt_q;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         pat_q <= {KME_LINES_IDLE, KME_LINES_IDLE};
      end else begin
         pat_q <= pat;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         cnt_q <= KME_CNT_RESET;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // The hold state only clears after the keypad has been fully released
   // and quiet for the whole wait, so break bounce that briefly shows the
   // same key again cannot arm a second strobe.
   always_comb begin
      st_d = st_q;
      strobe_d = 1'b0;
      case (st_q)
         KME_ST_IDLE: begin
            if (numeric) begin
               st_d = KME_ST_COUNT;
            end
         end
         KME_ST_COUNT: begin
            if (changed || !numeric) begin
               st_d = KME_ST_IDLE;
            end else if (at_last) begin
               st_d = KME_ST_FIRE;
               strobe_d = 1'b1;
            end
         end
         KME_ST_FIRE: begin
            st_d = KME_ST_HOLD;
         end
         KME_ST_HOLD: begin
            if (no_key && at_last) begin
               st_d = KME_ST_IDLE;
            end
         end
         default: begin
            st_d = KME_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         st_q <= KME_ST_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   // One clock wide; a single-edge design cannot time a half period.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         strobe_q <= KME_STROBE_RESET;
      end else begin
         strobe_q <= strobe_d;
      end
   end

   sequence s_armed;
      (st_q == KME_ST_COUNT) && at_last && numeric;
   endsequence

   sequence s_fire;
      strobe_q ##1 !strobe_q;
   endsequence

   property p_fire_after_wait;
      @(posedge core_clk_i) disable iff (rst_i)
      s_armed |=> s_fire;
   endproperty
   a_fire_after_wait: assert property (p_fire_after_wait)
      else $error("Strobe did not follow a completed stable wait.");

   property p_strobe_count;
      @(posedge core_clk_i) disable iff (rst_i)
      strobe_q |-> $past(cnt_q) == KME_CNT_LAST && !$past(changed);
   endproperty
   a_strobe_count: assert property (p_strobe_count)
      else $error("Strobe issued before the input was stable long enough.");

   property p_strobe_width;
      @(posedge core_clk_i) disable iff (rst_i)
      $rose(strobe_q) |=> !strobe_q;
   endproperty
   a_strobe_width: assert property (p_strobe_width)
      else $error("Strobe lasted more than one clock.");

   property p_strobe_numeric;
      @(posedge core_clk_i) disable iff (rst_i)
      strobe_q |-> $past(numeric);
   endproperty
   a_strobe_numeric: assert property (p_strobe_numeric)
      else $error("Strobe issued for a key that is not a numeral.");

   property p_single_per_press;
      @(posedge core_clk_i) disable iff (rst_i)
      s_fire |-> (st_q == KME_ST_HOLD);
   endproperty
   a_single_per_press: assert property (p_single_per_press)
      else $error("Strobe not followed by the hold state.");

   property p_no_strobe_in_hold;
      @(posedge core_clk_i) disable iff (rst_i)
      (st_q == KME_ST_HOLD) |=> !strobe_q;
   endproperty
   a_no_strobe_in_hold: assert property (p_no_strobe_in_hold)
      else $error("Strobe issued while a key release was pending.");

   property p_rollover;
      @(posedge core_clk_i) disable iff (rst_i)
      !legal |=> !strobe_q ##1 !strobe_q;
   endproperty
   a_rollover: assert property (p_rollover)
      else $error("Strobe followed an illegal or multi-key pattern.");

   property p_illegal_zero;
      @(posedge core_clk_i) disable iff (rst_i)
      !legal |-> code == KME_CODE_ILLEGAL;
   endproperty
   a_illegal_zero: assert property (p_illegal_zero)
      else $error("Illegal pattern did not drive a zero code.");

   property p_legal_onehot;
      @(posedge core_clk_i) disable iff (rst_i)
      legal |-> $onehot(~row_n) && $onehot(~col_n);
   endproperty
   a_legal_onehot: assert property (p_legal_onehot)
      else $error("Code marked valid without one row and one column.");

   property p_zero_key;
      @(posedge core_clk_i) disable iff (rst_i)
      (row_n == 4'h7 && col_n == 4'hD) |-> code == 4'h0 && numeric;
   endproperty
   a_zero_key: assert property (p_zero_key)
      else $error("Row four column two did not encode as numeral zero.");

   property p_letter_key;
      @(posedge core_clk_i) disable iff (rst_i)
      (row_n == 4'hE && col_n == 4'h7) |-> code == 4'hC && !numeric;
   endproperty
   a_letter_key: assert property (p_letter_key)
      else $error("Row one column four did not encode as 1100.");

   property p_code_tracks;
      @(posedge core_clk_i) disable iff (rst_i)
      {code_bit_three_o, code_bit_two_o, code_bit_one_o,
       code_bit_zero_o} == code;
   endproperty
   a_code_tracks: assert property (p_code_tracks)
      else $error("Code outputs do not follow the decoder.");

endmodule
`default_nettype wire

/* hw/kme_pkg.sv */
// Constants shared by the keypad matrix encoder design files.
`default_nettype none
package kme_pkg;

   localparam int KME_LINES = 4;
   localparam int KME_KEYS = 16;
   localparam int KME_CODE_W = 4;

   // Debounce wait in clock pulses, and its cycle count at this clock.
   localparam int KME_STABLE_PULSES = 80;
   localparam int KME_STABLE_CYCLES = KME_STABLE_PULSES;
   localparam int KME_CNT_W = 7;
   localparam logic [KME_CNT_W-1:0] KME_CNT_LAST =
      KME_CNT_W'(KME_STABLE_CYCLES - 1);
   localparam logic [KME_CNT_W-1:0] KME_CNT_RESET = 7'h00;

   // All lines released: every active-low input is high.
   localparam logic [KME_LINES-1:0] KME_LINES_IDLE = 4'hF;
   localparam logic KME_STROBE_RESET = 1'b0;

   // Key code by index row*4+column, row one and column one at zero.
   localparam logic [KME_CODE_W-1:0] KME_CODE_TABLE [KME_KEYS] = '{
      4'h1, 4'h2, 4'h3, 4'hC,
      4'h4, 4'h5, 4'h6, 4'hD,
      4'h7, 4'h8, 4'h9, 4'hE,
      4'hA, 4'h0, 4'hB, 4'hF
   };
   localparam logic [KME_CODE_W-1:0] KME_CODE_ILLEGAL = 4'h0;

   // One bit per key index; set for the ten numeral keys.
   localparam logic [KME_KEYS-1:0] KME_NUMERIC_MASK = 16'h2777;

   typedef enum logic [1:0] {
      KME_ST_IDLE = 2'h0,
      KME_ST_COUNT = 2'h1,
      KME_ST_FIRE = 2'h3,
      KME_ST_HOLD = 2'h2
   } kme_state_e;

endpackage
`default_nettype wire

/* hw/kme_decoder.sv */
// Combinational 2-of-8 to binary decoder with illegal pattern detection.
`timescale 1ns/100ps
`default_nettype none
module kme_decoder
   import kme_pkg::*;
(
   input wire logic [KME_LINES-1:0] row_n_i,
   input wire logic [KME_LINES-1:0] col_n_i,
   output logic legal_o,
   output logic numeric_o,
   output logic [KME_CODE_W-1:0] code_o
);

   logic [KME_LINES-1:0] row_act;
   logic [KME_LINES-1:0] col_act;
   logic [3:0] key_idx;

   // Position of the single active line of a one-hot group.
   function automatic logic [1:0] kme_line_pos(input logic [3:0] act);
      logic [1:0] pos;
      pos = 2'h0;
      for (int i = 0; i < KME_LINES; i++) begin
         if (act[i]) begin
            pos = 2'(i);
         end
      end
      return pos;
   endfunction

   genvar g;
   generate
      for (g = 0; g < KME_LINES; g++) begin : g_act
         assign row_act[g] = ~row_n_i[g];
         assign col_act[g] = ~col_n_i[g];
      end
   endgenerate

   assign key_idx = {kme_line_pos(row_act), kme_line_pos(col_act)};

   always_comb begin
      legal_o = $onehot(row_act) && $onehot(col_act);
      numeric_o = legal_o && KME_NUMERIC_MASK[key_idx];
      if (legal_o) begin
         code_o = KME_CODE_TABLE[key_idx];
      end else begin
         code_o = KME_CODE_ILLEGAL;
      end
   end

endmodule
`default_nettype wire

/* verif/kme_keypad_model.sv */
// Behavioural 4x4 keyswitch matrix with a pull-up on every line.
`timescale 1ns/100ps
`default_nettype none
module kme_keypad_model
   import kme_pkg::*;
(
   input wire logic [KME_KEYS-1:0] pressed_i,
   output logic [KME_LINES-1:0] row_n_o,
   output logic [KME_LINES-1:0] col_n_o
);
   // Open lines rest high, so several closed keys pull several lines low.
   always_comb begin
      row_n_o = KME_LINES_IDLE;
      col_n_o = KME_LINES_IDLE;
      for (int k = 0; k < KME_KEYS; k++) begin
         if (pressed_i[k]) begin
            row_n_o[k / KME_LINES] = 1'b0;
            col_n_o[k % KME_LINES] = 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

/* verif/tb_keypad_matrix_encoder.sv */
// Self-checking bench for the keypad matrix encoder.
`timescale 1ns/100ps
`default_nettype none
module tb_keypad_matrix_encoder;
   import kme_pkg::*;
   localparam logic [63:0] EXP_CODES = 64'hFB0AE987D654C321;
   localparam logic [15:0] EXP_NUM = 16'h2777;
   typedef struct {
      logic [15:0] keys;
      logic [3:0] code;
      logic num;
   } kme_row_s;
   logic core_clk_i;
   logic rst_i;
   logic [15:0] keys_q;
   logic [3:0] row_n;
   logic [3:0] col_n;
   logic [3:0] code;
   logic strobe;
   int n_errors;
   int checked;
   int first;
   int pulses;
   kme_row_s rows [20];

   kme_keypad_model u_kme_keypad_model (
      .pressed_i(keys_q),
      .row_n_o(row_n),
      .col_n_o(col_n)
   );

   kme_top u_kme_top (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .row_line_one_i(row_n[0]),
      .row_line_two_i(row_n[1]),
      .row_line_three_i(row_n[2]),
      .row_line_four_i(row_n[3]),
      .column_line_one_i(col_n[0]),
      .column_line_two_i(col_n[1]),
      .column_line_three_i(col_n[2]),
      .column_line_four_i(col_n[3]),
      .code_bit_zero_o(code[0]),
      .code_bit_one_o(code[1]),
      .code_bit_two_o(code[2]),
      .code_bit_three_o(code[3]),
      .strobe_o(strobe)
   );

   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Inputs change 1 ns after the edge so the design never races the bench.
   task automatic tick();
      @(posedge core_clk_i);
      #1;
   endtask

   // Counts strobe pulses over n edges and notes the edge of the first one.
   task automatic watch(input int n);
      first = 0;
      pulses = 0;
      for (int i = 1; i <= n; i++) begin
         tick();
         if (strobe === 1'b1) begin
            pulses++;
            if (first == 0) begin
               first = i;
            end
         end
      end
   endtask

   task automatic summarize();
      if (n_errors == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      rst_i = 1'b1;
      keys_q = 16'h0000;
      n_errors = 0;
      checked = 0;
      for (int i = 0; i < 16; i++) begin
         rows[i] = '{16'h0001 << i, EXP_CODES[i*4 +: 4], EXP_NUM[i]};
      end
      rows[16] = '{16'h0003, 4'h0, 1'b0};
      rows[17] = '{16'h0011, 4'h0, 1'b0};
      rows[18] = '{16'h0021, 4'h0, 1'b0};
      rows[19] = '{16'h0000, 4'h0, 1'b0};
      repeat (20) tick();
      chk(strobe, 1'b0);
      rst_i = 1'b0;
      foreach (rows[r]) begin
         keys_q = rows[r].keys;
         #1;
         chk(code, rows[r].code);
         watch(200);
         chk(pulses, rows[r].num);
         if (rows[r].num) begin
            chk(first, 81);
         end
         keys_q = 16'h0000;
         watch(90);
         chk(pulses, 0);
      end
      // A short break in mid-wait must restart the full count.
      keys_q = 16'h0020;
      watch(50);
      chk(pulses, 0);
      keys_q = 16'h0000;
      tick();
      keys_q = 16'h0020;
      watch(100);
      chk(first, 81);
      chk(pulses, 1);
      for (int b = 0; b < 5; b++) begin
         keys_q = 16'h0000;
         watch(1);
         chk(pulses, 0);
         keys_q = 16'h0020;
         watch(1);
         chk(pulses, 0);
      end
      keys_q = 16'h0000;
      watch(90);
      chk(pulses, 0);
      // Roll over from one key to another before the first is accepted.
      keys_q = 16'h0001;
      watch(30);
      keys_q = 16'h0003;
      #1;
      chk(code, 4'h0);
      watch(30);
      chk(pulses, 0);
      keys_q = 16'h0002;
      #1;
      chk(code, 4'h2);
      watch(100);
      chk(first, 81);
      chk(pulses, 1);
      keys_q = 16'h0000;
      watch(90);
      // Reset in mid-wait: code still follows, one strobe after release.
      keys_q = 16'h0040;
      watch(40);
      rst_i = 1'b1;
      watch(3);
      chk(pulses, 0);
      chk(code, 4'h6);
      rst_i = 1'b0;
      watch(100);
      chk(first, 81);
      chk(pulses, 1);
      keys_q = 16'h0000;
      watch(90);
      summarize();
   end
endmodule
`default_nettype wire
